// File: rpm_pkg.sv
// Package: constants, types and offset tables for the regulator phase/mode control
// Summary of operation
// - Three-phase strap, hints 11: three phases continuous
// - Phase-3 strap high: two phases, 1 and 2
// - Phase-3 and phase-2 straps high: phase 1 only
// - Three-phase, hint0 low: shed 2,3, diode emulation
// - Two-phase, hint0 low: shed 2, diode emulation
// - Both hints low: single-phase diode emulation always
// - One-phase: continuous while hint0 high, else emulation
// - Core phase-1 strap high disables core output
// - NB two-phase: continuous at 11, else single emulation
// - NB phase-2 strap high: single phase, emulation unless 11
// - NB phase-1 strap high disables NB output
// - Voltage increase slews reference at programmed rate
// - Voltage decrease: no active pull-down, load decays
// - Capacitor switch only in two-phase core config
// - Switch closed in two-phase, opened in single-phase
// - Secondary feedback tracks primary while switch open
// - Core discontinuous: low-side off at zero-cross comparator
// - Step zero-cross threshold toward one 100ns cycle of diode conduction
// - Read program resistors during early soft-start
// - Core offset table -43.75..50 mV, open gives 0
// - NB offset table 0..50 mV, 41.2 and open 0
// - Slew rate captured at soft-start, shared by outputs
package rpm_pkg;
    localparam int CLK_PERIOD_NS = 100;
    localparam int BODY_DIODE_TARGET_NS = 40;
    // Target rounded down, at least one cycle
    localparam int BODY_DIODE_CYC = (BODY_DIODE_TARGET_NS / CLK_PERIOD_NS) < 1 ? 1 :
        (BODY_DIODE_TARGET_NS / CLK_PERIOD_NS);
    localparam int VCODE_W = 8;
    localparam int THR_W = 6;
    localparam logic [THR_W-1:0] THR_RESET = 6'h20;
    localparam logic [2:0] PH_NONE = 3'h0;
    localparam logic [2:0] PH_ONE = 3'h1;
    localparam logic [2:0] PH_TWO = 3'h3;
    localparam logic [2:0] PH_THREE = 3'h7;
    // Offsets in 1/100 mV units, indexed by resistor code
    localparam logic signed [15:0] CORE_OFS [16] = '{
        -16'sd4375, -16'sd3750, -16'sd3125, -16'sd2500, -16'sd1875, -16'sd1250,
        -16'sd625, 16'sd625, 16'sd1875, 16'sd3125, 16'sd4376, 16'sd5000,
        16'sd3750, 16'sd2500, 16'sd1250, 16'sd0};
    localparam logic signed [15:0] NB_OFS [16] = '{
        16'sd1875, 16'sd3125, 16'sd4376, 16'sd5000, 16'sd3750, 16'sd2500,
        16'sd1250, 16'sd0, 16'sd1875, 16'sd3125, 16'sd4376, 16'sd5000,
        16'sd3750, 16'sd2500, 16'sd1250, 16'sd0};
    // Slew rate in 1/10 mV/us by resistor code
    localparam logic [7:0] SLEW_TAB [4] = '{8'hC8, 8'h96, 8'h7D, 8'h64};
    typedef enum logic [1:0] {
        RPM_OFF = 2'b00,
        RPM_READ = 2'b01,
        RPM_RUN = 2'b10
    } rpm_state_type;
endpackage

// File: rpm_if.sv
// Interface carrying one output's reference request and state
`timescale 1ns/1ps
interface rpm_ref_if;
    import rpm_pkg::*;
    logic [VCODE_W-1:0] target;
    logic [VCODE_W-1:0] ref_code;
    logic run;
    logic [7:0] step_cyc;
    modport ctl(output target, output run, output step_cyc, input ref_code);
    modport slw(input target, input run, input step_cyc, output ref_code);
endinterface

// File: rpm_slew.sv
// Reference slewer: rises one code per step, falls at once
`timescale 1ns/1ps
module rpm_slew
    import rpm_pkg::*;
(
    input wire logic i_clk, // Clock
    input wire logic i_rst, // Async reset
    rpm_ref_if.slw ref_io // Reference link
);
    logic [VCODE_W-1:0] ref_r, ref_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    // Step toward target
    always_comb begin
        ref_nxt = ref_r;
        cnt_nxt = cnt_r;
        if (!ref_io.run) begin
            ref_nxt = '0;
            cnt_nxt = '0;
        end else if (ref_io.target > ref_r) begin
            if (cnt_r >= ref_io.step_cyc) begin
                cnt_nxt = '0;
                ref_nxt = ref_r + 8'h01;
            end else begin
                cnt_nxt = cnt_r + 8'h01;
            end
        end else begin
            ref_nxt = ref_io.target;
            cnt_nxt = '0;
        end
    end
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ref_r <= '0;
            cnt_r <= '0;
        end else begin
            ref_r <= ref_nxt;
            cnt_r <= cnt_nxt;
        end
    end
    assign ref_io.ref_code = ref_r;
    a_rise_one_step: assert property (@(posedge i_clk) disable iff (i_rst)
        ref_io.run && $past(ref_io.run) && ref_r > $past(ref_r)
        |-> ref_r == $past(ref_r) + 8'h01) else $error("reference jumped up");
endmodule

// File: rpm_top.sv
// Phase and mode control for the core and NB regulator outputs
`timescale 1ns/1ps
module rpm_top
    import rpm_pkg::*;
#(
    parameter int READ_CYC = 16
) (
    input wire logic i_clk, // Clock
    input wire logic i_rst, // Async reset
    input wire logic i_enable, // Start soft-start
    input wire logic i_core_phase1_sense_strap, // High: tied to 5V
    input wire logic i_core_phase2_sense_strap, // High: tied to 5V
    input wire logic i_core_phase3_sense_strap, // High: tied to 5V
    input wire logic i_nb_phase1_sense_strap, // High: tied to 5V
    input wire logic i_nb_phase2_sense_strap, // High: tied to 5V
    input wire logic i_power_state_hint0_n, // Hint bit 0, low active
    input wire logic i_power_state_hint1_n, // Hint bit 1, low active
    input wire logic [3:0] i_core_comp_code, // Core resistor reading
    input wire logic [3:0] i_nb_comp_program_pin, // NB resistor reading
    input wire logic [3:0] i_forced_conduction_program_pin, // Slew resistor
    input wire logic [VCODE_W-1:0] i_core_voltage_code, // Core target
    input wire logic [VCODE_W-1:0] i_nb_voltage_code, // NB target
    input wire logic i_zero_cross, // Phase comparator tripped
    input wire logic i_lowside_on, // Low-side switch commanded on
    input wire logic i_body_diode, // Phase node shows diode drop
    output logic [2:0] o_core_phases, // Core active phases
    output logic [1:0] o_nb_phases, // NB active phases
    output logic o_core_diode_emulation, // Core in emulation
    output logic o_nb_diode_emulation, // NB in emulation
    output logic o_fb_switch_closed, // Compensation switch closed
    output logic o_secondary_feedback_track, // Drive secondary to primary
    output logic o_lowside_off, // Low-side turn-off request
    output logic [THR_W-1:0] o_zc_threshold, // Zero-cross threshold
    output logic signed [15:0] o_core_offset, // Core offset, 10 uV
    output logic signed [15:0] o_nb_offset, // NB offset, 10 uV
    output logic [7:0] o_slew_rate, // Slew, 0.1 mV/us
    output logic [VCODE_W-1:0] o_core_ref, // Core reference
    output logic [VCODE_W-1:0] o_nb_ref, // NB reference
    output logic o_running // Phases enabled
);
    rpm_state_type st_r, st_nxt;
    logic [7:0] rd_cnt_r, rd_cnt_nxt;
    logic [3:0] core_idx_r, core_idx_nxt, nb_idx_r, nb_idx_nxt, slw_idx_r, slw_idx_nxt;
    logic [2:0] core_cfg_r, core_cfg_nxt;
    logic [1:0] nb_cfg_r, nb_cfg_nxt;
    logic [2:0] core_ph_r, core_ph_nxt;
    logic [1:0] nb_ph_r, nb_ph_nxt;
    logic core_de_r, core_de_nxt, nb_de_r, nb_de_nxt;
    logic fbsw_r, fbsw_nxt, track_r, track_nxt, lo_off_r, lo_off_nxt;
    logic [THR_W-1:0] thr_r, thr_nxt;
    logic [3:0] diode_cnt_r, diode_cnt_nxt;
    logic watch_r, watch_nxt;
    logic run_r, run_nxt;
    logic [VCODE_W-1:0] core_ref_r, nb_ref_r;
    rpm_ref_if core_if();
    rpm_ref_if nb_if();

    // Sequencer: strap latch, resistor read, run
    always_comb begin
        st_nxt = st_r;
        rd_cnt_nxt = rd_cnt_r;
        core_idx_nxt = core_idx_r;
        nb_idx_nxt = nb_idx_r;
        slw_idx_nxt = slw_idx_r;
        core_cfg_nxt = core_cfg_r;
        nb_cfg_nxt = nb_cfg_r;
        unique case (st_r)
            RPM_OFF: begin
                rd_cnt_nxt = '0;
                if (i_enable) begin
                    st_nxt = RPM_READ;
                    // Latch phase configuration before any phase runs
                    if (i_core_phase1_sense_strap)
                        core_cfg_nxt = PH_NONE;
                    else if (i_core_phase3_sense_strap && i_core_phase2_sense_strap)
                        core_cfg_nxt = PH_ONE;
                    else if (i_core_phase3_sense_strap)
                        core_cfg_nxt = PH_TWO;
                    else
                        core_cfg_nxt = PH_THREE;
                    if (i_nb_phase1_sense_strap)
                        nb_cfg_nxt = 2'h0;
                    else if (i_nb_phase2_sense_strap)
                        nb_cfg_nxt = 2'h1;
                    else
                        nb_cfg_nxt = 2'h3;
                end
            end
            RPM_READ: begin
                // Sample the programming resistors early in soft-start
                core_idx_nxt = i_core_comp_code;
                nb_idx_nxt = i_nb_comp_program_pin;
                slw_idx_nxt = i_forced_conduction_program_pin;
                rd_cnt_nxt = rd_cnt_r + 8'h01;
                if (!i_enable)
                    st_nxt = RPM_OFF;
                else if (rd_cnt_r >= 8'(READ_CYC - 1))
                    st_nxt = RPM_RUN;
            end
            RPM_RUN: begin
                if (!i_enable)
                    st_nxt = RPM_OFF;
            end
            default: st_nxt = RPM_OFF;
        endcase
        // Run flag registered so the pin comes from a flop
        run_nxt = (st_nxt == RPM_RUN);
    end
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_r <= RPM_OFF;
            rd_cnt_r <= '0;
            core_idx_r <= 4'hF;
            nb_idx_r <= 4'hF;
            slw_idx_r <= 4'hF;
            core_cfg_r <= PH_NONE;
            nb_cfg_r <= 2'h0;
            run_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            rd_cnt_r <= rd_cnt_nxt;
            core_idx_r <= core_idx_nxt;
            nb_idx_r <= nb_idx_nxt;
            slw_idx_r <= slw_idx_nxt;
            core_cfg_r <= core_cfg_nxt;
            nb_cfg_r <= nb_cfg_nxt;
            run_r <= run_nxt;
        end
    end

    // Phase shedding and conduction mode from hints
    always_comb begin
        core_ph_nxt = PH_NONE;
        nb_ph_nxt = 2'h0;
        core_de_nxt = 1'b0;
        nb_de_nxt = 1'b0;
        if (st_nxt == RPM_RUN) begin
            if (core_cfg_r != PH_NONE) begin
                // Core keeps full phases while hint 0 stays high
                if (i_power_state_hint0_n) begin
                    core_ph_nxt = core_cfg_r;
                end else begin
                    core_ph_nxt = PH_ONE;
                    core_de_nxt = 1'b1;
                end
            end
            if (nb_cfg_r != 2'h0) begin
                if (i_power_state_hint0_n && i_power_state_hint1_n) begin
                    nb_ph_nxt = nb_cfg_r;
                end else begin
                    nb_ph_nxt = 2'h1;
                    nb_de_nxt = 1'b1;
                end
            end
        end
        // Capacitor switch only exists in two-phase core strapping
        fbsw_nxt = (core_cfg_r == PH_TWO) && (core_ph_nxt == PH_TWO);
        track_nxt = (core_cfg_nxt == PH_TWO) && !fbsw_nxt;
    end
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            core_ph_r <= PH_NONE;
            nb_ph_r <= 2'h0;
            core_de_r <= 1'b0;
            nb_de_r <= 1'b0;
            fbsw_r <= 1'b0;
            track_r <= 1'b0;
        end else begin
            core_ph_r <= core_ph_nxt;
            nb_ph_r <= nb_ph_nxt;
            core_de_r <= core_de_nxt;
            nb_de_r <= nb_de_nxt;
            fbsw_r <= fbsw_nxt;
            track_r <= track_nxt;
        end
    end

    // Zero-cross turn-off and adaptive threshold stepping
    always_comb begin
        lo_off_nxt = 1'b0;
        thr_nxt = thr_r;
        watch_nxt = watch_r;
        diode_cnt_nxt = diode_cnt_r;
        if (core_de_r && i_lowside_on && i_zero_cross)
            lo_off_nxt = 1'b1;
        if (lo_off_r) begin
            watch_nxt = 1'b1;
            diode_cnt_nxt = '0;
        end else if (watch_r) begin
            if (i_body_diode && diode_cnt_r != 4'hF) begin
                diode_cnt_nxt = diode_cnt_r + 4'h1;
            end else begin
                watch_nxt = 1'b0;
                // Too long: trip earlier; too short: trip later
                if (diode_cnt_r > 4'(BODY_DIODE_CYC) && thr_r != '1)
                    thr_nxt = thr_r + 6'h01;
                else if (diode_cnt_r < 4'(BODY_DIODE_CYC) && thr_r != '0)
                    thr_nxt = thr_r - 6'h01;
            end
        end
    end
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            lo_off_r <= 1'b0;
            thr_r <= THR_RESET;
            watch_r <= 1'b0;
            diode_cnt_r <= '0;
        end else begin
            lo_off_r <= lo_off_nxt;
            thr_r <= thr_nxt;
            watch_r <= watch_nxt;
            diode_cnt_r <= diode_cnt_nxt;
        end
    end

    // Reference slewing, same rate for both outputs
    assign core_if.target = i_core_voltage_code;
    assign nb_if.target = i_nb_voltage_code;
    assign core_if.run = (st_r == RPM_RUN) && (core_cfg_r != PH_NONE);
    assign nb_if.run = (st_r == RPM_RUN) && (nb_cfg_r != 2'h0);
    assign core_if.step_cyc = SLEW_TAB[slw_idx_r[1:0]];
    assign nb_if.step_cyc = SLEW_TAB[slw_idx_r[1:0]];
    rpm_slew u_core_slew (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .ref_io(core_if.slw)
    );
    rpm_slew u_nb_slew (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .ref_io(nb_if.slw)
    );
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            core_ref_r <= '0;
            nb_ref_r <= '0;
            o_core_offset <= '0;
            o_nb_offset <= '0;
            o_slew_rate <= '0;
        end else begin
            core_ref_r <= core_if.ref_code;
            nb_ref_r <= nb_if.ref_code;
            o_core_offset <= CORE_OFS[core_idx_r];
            o_nb_offset <= NB_OFS[nb_idx_r];
            o_slew_rate <= SLEW_TAB[slw_idx_r[1:0]];
        end
    end

    // Output drive
    assign o_core_phases = core_ph_r;
    assign o_nb_phases = nb_ph_r;
    assign o_core_diode_emulation = core_de_r;
    assign o_nb_diode_emulation = nb_de_r;
    assign o_fb_switch_closed = fbsw_r;
    assign o_secondary_feedback_track = track_r;
    assign o_lowside_off = lo_off_r;
    assign o_zc_threshold = thr_r;
    assign o_core_ref = core_ref_r;
    assign o_nb_ref = nb_ref_r;
    assign o_running = run_r;

    a_core_off_dis: assert property (@(posedge i_clk) disable iff (i_rst)
        core_cfg_r == PH_NONE |-> core_ph_r == PH_NONE) else $error("core not off");
    a_nb_off_dis: assert property (@(posedge i_clk) disable iff (i_rst)
        nb_cfg_r == 2'h0 |-> nb_ph_r == 2'h0) else $error("nb not off");
    a_shed_to_one: assert property (@(posedge i_clk) disable iff (i_rst)
        st_r == RPM_RUN && st_nxt == RPM_RUN && core_cfg_r != PH_NONE
        && !i_power_state_hint0_n |=> core_ph_r == PH_ONE && core_de_r)
        else $error("core did not shed");
    a_both_low_de: assert property (@(posedge i_clk) disable iff (i_rst)
        st_r == RPM_RUN && st_nxt == RPM_RUN && nb_cfg_r != 2'h0
        && !i_power_state_hint0_n && !i_power_state_hint1_n |=> nb_de_r && nb_ph_r == 2'h1)
        else $error("nb not in emulation");
    a_full_ccm: assert property (@(posedge i_clk) disable iff (i_rst)
        st_r == RPM_RUN && st_nxt == RPM_RUN && i_power_state_hint0_n && i_power_state_hint1_n
        |=> core_ph_r == core_cfg_r && !core_de_r) else $error("core not full");
    a_switch_two_only: assert property (@(posedge i_clk) disable iff (i_rst)
        fbsw_r |-> core_cfg_r == PH_TWO && core_ph_r == PH_TWO) else $error("switch misuse");
    a_track_open: assert property (@(posedge i_clk) disable iff (i_rst)
        core_cfg_r == PH_TWO && !fbsw_r |-> track_r) else $error("no tracking");
    a_lowside_zc: assert property (@(posedge i_clk) disable iff (i_rst)
        core_de_r && i_lowside_on && i_zero_cross |=> lo_off_r) else $error("no turn-off");
    a_cfg_hold_run: assert property (@(posedge i_clk) disable iff (i_rst)
        st_r == RPM_RUN && $past(st_r) == RPM_RUN |-> $stable(core_cfg_r) && $stable(slw_idx_r)
        && $stable(core_idx_r)) else $error("config changed in run");

    // Mode, switch, threshold and low-side turn-off checks
    a_nb_full_ccm: assert property (@(posedge i_clk) disable iff (i_rst)
        st_r == RPM_RUN && st_nxt == RPM_RUN && nb_cfg_r != 2'h0 && i_power_state_hint0_n
        && i_power_state_hint1_n |=> nb_ph_r == nb_cfg_r && !nb_de_r) else $error("nb not full");
    a_one_ccm_hint0: assert property (@(posedge i_clk) disable iff (i_rst)
        st_r == RPM_RUN && st_nxt == RPM_RUN && core_cfg_r == PH_ONE && i_power_state_hint0_n
        |=> core_ph_r == PH_ONE && !core_de_r) else $error("one-phase not continuous");
    a_switch_one_open: assert property (@(posedge i_clk) disable iff (i_rst)
        core_ph_r == PH_ONE |-> !fbsw_r) else $error("switch closed in one phase");
    a_thr_step_one: assert property (@(posedge i_clk) disable iff (i_rst)
        thr_r != $past(thr_r) |-> (thr_r == $past(thr_r) + 6'h01)
        || (thr_r == $past(thr_r) - 6'h01)) else $error("threshold jumped");
    a_lowside_de_only: assert property (@(posedge i_clk) disable iff (i_rst)
        lo_off_r |-> $past(core_de_r)) else $error("turn-off outside emulation");
endmodule

// File: rpm_cpu_model.sv
// Processor-side model that issues power-state hints and voltage targets
`timescale 1ns/1ps
module rpm_cpu_model
    import rpm_pkg::*;
(
    input wire logic i_clk, // Clock
    output logic o_hint0_n, // Hint bit 0, low active
    output logic o_hint1_n, // Hint bit 1, low active
    output logic [VCODE_W-1:0] o_core_vcode, // Core target
    output logic [VCODE_W-1:0] o_nb_vcode // NB target
);
    // Idle: full-power hints, zero targets
    initial begin
        o_hint0_n = 1'b1;
        o_hint1_n = 1'b1;
        o_core_vcode = 8'h00;
        o_nb_vcode = 8'h00;
    end

    // New hint pair, bit 0 first, just after an edge
    task automatic send_hints(input logic [1:0] h);
        @(posedge i_clk);
        #1;
        {o_hint0_n, o_hint1_n} = h;
    endtask

    // New voltage targets for both outputs
    task automatic send_vcode(input logic [VCODE_W-1:0] c, input logic [VCODE_W-1:0] n);
        @(posedge i_clk);
        #1;
        o_core_vcode = c;
        o_nb_vcode = n;
    endtask
endmodule

// File: tb_rpm_top.sv
// Self-checking bench for the regulator phase and mode control
`timescale 1ns/1ps
module tb_rpm_top;
    import rpm_pkg::*;
    localparam int RC = 2;
    localparam int NC [4] = '{2, 1, 0, 0};
    localparam logic [3:0] CC [4] = '{4'h0, 4'h7, 4'hB, 4'hF};
    localparam logic [3:0] NBC [4] = '{4'h3, 4'h7, 4'h0, 4'hF};
    localparam logic [15:0] CO [4] = '{16'hEEE9, 16'h0271, 16'h1388, 16'h0000};
    localparam logic [15:0] NO [4] = '{16'h1388, 16'h0000, 16'h0753, 16'h0000};
    localparam logic [15:0] SR [4] = '{16'h00C8, 16'h0096, 16'h007D, 16'h0064};
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_enable = 1'b0;
    logic st1 = 1'b0;
    logic st2 = 1'b0;
    logic st3 = 1'b0;
    logic nb1 = 1'b0;
    logic nb2 = 1'b0;
    logic [3:0] ccode = 4'h0;
    logic [3:0] ncode = 4'h0;
    logic [3:0] scode = 4'h0;
    logic zc = 1'b0;
    logic lso = 1'b0;
    logic bd = 1'b0;
    logic h0n, h1n;
    logic [VCODE_W-1:0] cv, nv, core_ref, nb_ref;
    logic [2:0] core_ph;
    logic [1:0] nb_ph;
    logic core_de, nb_de, fb_closed, fb_track, ls_off, running;
    logic [THR_W-1:0] thr;
    logic signed [15:0] core_ofs, nb_ofs;
    logic [7:0] slew;
    int n_errors = 0;
    int num_checks = 0;

    // Clock, 100 ns period
    always #50 i_clk = ~i_clk;

    rpm_cpu_model cpu (.i_clk(i_clk), .o_hint0_n(h0n), .o_hint1_n(h1n),
        .o_core_vcode(cv), .o_nb_vcode(nv));

    rpm_top #(.READ_CYC(RC)) dut (.i_clk(i_clk), .i_rst(i_rst), .i_enable(i_enable),
        .i_core_phase1_sense_strap(st1), .i_core_phase2_sense_strap(st2),
        .i_core_phase3_sense_strap(st3), .i_nb_phase1_sense_strap(nb1),
        .i_nb_phase2_sense_strap(nb2), .i_power_state_hint0_n(h0n),
        .i_power_state_hint1_n(h1n), .i_core_comp_code(ccode),
        .i_nb_comp_program_pin(ncode), .i_forced_conduction_program_pin(scode),
        .i_core_voltage_code(cv), .i_nb_voltage_code(nv), .i_zero_cross(zc),
        .i_lowside_on(lso), .i_body_diode(bd), .o_core_phases(core_ph),
        .o_nb_phases(nb_ph), .o_core_diode_emulation(core_de),
        .o_nb_diode_emulation(nb_de), .o_fb_switch_closed(fb_closed),
        .o_secondary_feedback_track(fb_track), .o_lowside_off(ls_off),
        .o_zc_threshold(thr), .o_core_offset(core_ofs), .o_nb_offset(nb_ofs),
        .o_slew_rate(slew), .o_core_ref(core_ref), .o_nb_ref(nb_ref), .o_running(running));

    task automatic wrap_up;
        if (n_errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Wait n edges, then step off the edge
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    // A wait that ran out of cycles ends the run
    task automatic timeout(input string what);
        n_errors++;
        $display("[FAIL] %0t %s wait ran out", $time, what);
        wrap_up();
    endtask

    // Restart with given straps and resistor codes
    task automatic soft_start(input int cfg, input int ncfg, input logic [3:0] cc,
        input logic [3:0] nc, input logic [3:0] sc);
        int n;
        i_enable = 1'b0;
        tick(2);
        st1 = (cfg == 3);
        st2 = (cfg == 2);
        st3 = (cfg == 1 || cfg == 2);
        nb1 = (ncfg == 2);
        nb2 = (ncfg == 1);
        ccode = cc;
        ncode = nc;
        scode = sc;
        i_enable = 1'b1;
        n = 0;
        while (running !== 1'b1 && n < 40) begin
            tick(1);
            n++;
        end
        if (n == 40) timeout("running");
        chk_bit(n >= RC + 1 && n <= RC + 2, 1'b1, "start latency");
    endtask

    // Walk the four hint pairs and check both outputs
    task automatic check_modes(input int cfg, input int ncfg);
        logic [1:0] hs [4];
        logic [2:0] cf;
        logic [1:0] nf;
        logic low;
        logic nlow;
        hs = '{2'b11, 2'b10, 2'b01, 2'b00};
        cf = (cfg == 0) ? 3'h7 : (cfg == 1) ? 3'h3 : (cfg == 2) ? 3'h1 : 3'h0;
        nf = (ncfg == 0) ? 2'h3 : (ncfg == 1) ? 2'h1 : 2'h0;
        for (int i = 0; i < 4; i++) begin
            cpu.send_hints(hs[i]);
            tick(2);
            low = !hs[i][1];
            nlow = (hs[i] != 2'b11);
            chk_vec({13'h0, core_ph}, (cfg == 3) ? 16'h0 : low ? 16'h1 : {13'h0, cf},
                "core phases");
            if (cfg != 3) chk_bit(core_de, low, "core mode");
            chk_vec({14'h0, nb_ph}, (ncfg == 2) ? 16'h0 : nlow ? 16'h1 : {14'h0, nf},
                "nb phases");
            if (ncfg != 2) chk_bit(nb_de, nlow, "nb mode");
            chk_bit(fb_closed, cfg == 1 && !low, "fb switch");
            if (cfg == 1 && low) chk_bit(fb_track, 1'b1, "fb track");
        end
    endtask

    // One low-side turn-off followed by d cycles of body diode
    task automatic turn_off(input int d);
        int n;
        lso = 1'b1;
        zc = 1'b1;
        n = 0;
        while (ls_off !== 1'b1 && n < 4) begin
            tick(1);
            n++;
        end
        chk_bit(ls_off, 1'b1, "low-side off");
        lso = 1'b0;
        zc = 1'b0;
        bd = (d > 0);
        tick(d > 0 ? d : 1);
        bd = 1'b0;
        tick(4);
    endtask

    // Main sequence
    initial begin
        int n;
        repeat (20) @(posedge i_clk);
        #1;
        i_rst = 1'b0;
        chk_vec({10'h0, thr}, 16'h0020, "reset threshold");
        chk_bit(running, 1'b0, "reset running");
        for (int k = 0; k < 4; k++) begin
            soft_start(k, NC[k], CC[k], NBC[k], 4'(k));
            check_modes(k, NC[k]);
            st1 = (k != 3);
            nb1 = 1'b1;
            ccode = ~CC[k];
            ncode = ~NBC[k];
            scode = ~4'(k);
            tick(3);
            chk_vec({13'h0, core_ph}, (k == 3) ? 16'h0 : 16'h1, "strap latch");
            chk_vec({14'h0, nb_ph}, (NC[k] == 2) ? 16'h0 : 16'h1, "nb latch");
            chk_vec(core_ofs, CO[k], "core offset");
            chk_vec(nb_ofs, NO[k], "nb offset");
            chk_vec({8'h0, slew}, SR[k], "slew rate");
        end
        cpu.send_vcode(8'h03, 8'h03);
        soft_start(0, 0, 4'hF, 4'hF, 4'h3);
        n = 0;
        while (core_ref !== 8'h03 && n < 1000) begin
            tick(1);
            n++;
            chk_vec({8'h0, core_ref}, {8'h0, nb_ref}, "refs differ");
        end
        if (n == 1000) timeout("rise");
        cpu.send_vcode(8'h01, 8'h01);
        tick(3);
        chk_vec({core_ref, nb_ref}, 16'h0101, "fall");
        cpu.send_vcode(8'h02, 8'h02);
        n = 0;
        while (core_ref !== 8'h02 && n < 300) begin
            tick(1);
            n++;
        end
        chk_bit(n >= 100 && n <= 104, 1'b1, "step time");
        chk_vec({8'h0, nb_ref}, 16'h0002, "nb step");
        cpu.send_hints(2'b01);
        tick(2);
        turn_off(4);
        chk_vec({10'h0, thr}, 16'h0021, "threshold up");
        turn_off(0);
        chk_vec({10'h0, thr}, 16'h0020, "threshold down");
        wrap_up();
    end
endmodule
